/* core/video_tu_framing_host.sv */
// Host controller that computes and programs transfer-unit framing values
// Summary of operation
// - Line word total is ceil(active pixels times bits per pixel over 16).
// - One lane: lane word count is the word total minus one.
// - Two lanes: word total plus (total mod 2) minus two.
// - Four lanes: word total plus (total mod 4) minus four.
// - Multi-stream mode always uses the four-lane formula.
// - The interlace flag is written as one for an interlaced source.
// - Whole bytes per unit is the integer part of bandwidth ratio times length.
// - Fraction field is the fractional part of that product times 1024.
// - With whole bytes of four or less the line start delay is 64.
// - Else the delay is length minus whole bytes, halved for 4:2:2, thirded for luma.
// - The transfer unit length is 32 or 64, 64 after reset, always even.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module video_tu_framing_host #(
  parameter int DIV_W = 34,
  parameter logic [31:0] DEV_BASE = 32'h0000_0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] m_axi_awaddr,
  output logic m_axi_awvalid,
  input wire logic m_axi_awready,
  output logic [31:0] m_axi_wdata,
  output logic [3:0] m_axi_wstrb,
  output logic m_axi_wvalid,
  input wire logic m_axi_wready,
  input wire logic [1:0] m_axi_bresp,
  input wire logic m_axi_bvalid,
  output logic m_axi_bready
);
  logic s_wready_reg;
  logic s_bvalid_reg;
  logic [1:0] s_bresp_reg;
  logic s_arready_reg;
  logic s_rvalid_reg;
  logic [31:0] s_rdata_reg;
  logic [1:0] s_rresp_reg;
  logic [7:0] ctrl_reg;
  logic [15:0] active_pixels_per_line_reg;
  logic [5:0] bpp_reg;
  logic [15:0] vbw_reg;
  logic [15:0] lbw_reg;
  logic busy_reg;
  logic done_reg;
  logic err_reg;
  logic start_pulse;
  logic wr_en;
  logic wr_hit;
  video_tu_pkg::state_t state_reg;
  logic [2:0] idx_reg;
  logic [$clog2(DIV_W+1)-1:0] cnt_reg;
  logic [DIV_W-1:0] quo_reg;
  logic [16:0] rem_reg;
  logic [16:0] trial;
  logic [31:0] lwc_reg;
  logic ilace_reg;
  logic [6:0] tu_reg;
  logic [6:0] whole_reg;
  logic [9:0] frac_reg;
  logic [6:0] delay_reg;
  logic [21:0] pix_bits;
  logic [31:0] words;
  logic [31:0] lwc_next;
  logic [6:0] delay_next;
  logic [6:0] diff;
  logic [15:0] diff_third;
  logic [6:0] whole_next;
  logic [DIV_W-1:0] dividend;
  logic m_awvalid_reg;
  logic m_wvalid_reg;
  logic m_bready_reg;
  logic [31:0] m_awaddr_reg;
  logic [31:0] m_wdata_reg;
  logic aw_left;
  logic w_left;

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] dev_off(input logic [2:0] i);
    logic [11:0] r;
    r = video_tu_pkg::lane_word_count_off;
    unique case (i)
      3'h0: r = video_tu_pkg::lane_word_count_off;
      3'h1: r = video_tu_pkg::interlace_flag_off;
      3'h2: r = video_tu_pkg::tu_whole_bytes_off;
      3'h3: r = video_tu_pkg::tu_fraction_bytes_off;
      default: r = video_tu_pkg::line_start_delay_off;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] dev_data(input logic [2:0] i,
                                           input logic [31:0] lwc,
                                           input logic il,
                                           input logic [6:0] wh,
                                           input logic [9:0] fr,
                                           input logic [6:0] dl);
    logic [31:0] r;
    r = lwc;
    unique case (i)
      3'h0: r = lwc;
      3'h1: r = {31'h0000_0000, il};
      3'h2: r = {25'h000_0000, wh};
      3'h3: r = {22'h00_0000, fr};
      default: r = {25'h000_0000, dl};
    endcase
    return r;
  endfunction

  // Slave write channel: take address and data together, answer one later
  assign wr_en = s_wready_reg;
  assign wr_hit = (s_axi_awaddr <= video_tu_pkg::res_tu_off) &&
                  (s_axi_awaddr[1:0] == 2'h0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_wready_reg <= 1'b0;
      s_bvalid_reg <= 1'b0;
      s_bresp_reg <= video_tu_pkg::resp_okay;
    end else begin
      s_wready_reg <= s_axi_awvalid && s_axi_wvalid && !s_wready_reg &&
                      !s_bvalid_reg;
      if (wr_en) begin
        s_bvalid_reg <= 1'b1;
        s_bresp_reg <= wr_hit ? video_tu_pkg::resp_okay :
                       video_tu_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_bvalid_reg <= 1'b0;
      end
    end
  end

  // Own configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= video_tu_pkg::ctrl_rst;
      active_pixels_per_line_reg <= 16'h0000;
      bpp_reg <= 6'h00;
      vbw_reg <= 16'h0000;
      lbw_reg <= 16'h0000;
    end else if (wr_en) begin
      unique case (s_axi_awaddr)
        video_tu_pkg::ctrl_off: ctrl_reg <= 8'(merge_strb(
          {24'h00_0000, ctrl_reg}, s_axi_wdata, s_axi_wstrb));
        video_tu_pkg::active_pixels_per_line_off: active_pixels_per_line_reg <= 16'(merge_strb(
          {16'h0000, active_pixels_per_line_reg}, s_axi_wdata, s_axi_wstrb));
        video_tu_pkg::bpp_off: bpp_reg <= 6'(merge_strb(
          {26'h000_0000, bpp_reg}, s_axi_wdata, s_axi_wstrb));
        video_tu_pkg::vbw_off: vbw_reg <= 16'(merge_strb(
          {16'h0000, vbw_reg}, s_axi_wdata, s_axi_wstrb));
        video_tu_pkg::lbw_off: lbw_reg <= 16'(merge_strb(
          {16'h0000, lbw_reg}, s_axi_wdata, s_axi_wstrb));
        default: ;
      endcase
    end
  end

  // Start is self-clearing; ignored while a sequence runs
  assign start_pulse = wr_en && (s_axi_awaddr == video_tu_pkg::ctrl_off) &&
                       s_axi_wstrb[0] &&
                       s_axi_wdata[video_tu_pkg::ctrl_start_bit] && !busy_reg;

  // Slave read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready_reg <= 1'b0;
      s_rvalid_reg <= 1'b0;
      s_rdata_reg <= 32'h0000_0000;
      s_rresp_reg <= video_tu_pkg::resp_okay;
    end else begin
      s_arready_reg <= s_axi_arvalid && !s_arready_reg && !s_rvalid_reg;
      if (s_arready_reg) begin
        s_rvalid_reg <= 1'b1;
        s_rresp_reg <= video_tu_pkg::resp_okay;
        unique case (s_axi_araddr)
          video_tu_pkg::ctrl_off: s_rdata_reg <= {24'h00_0000,
            ctrl_reg[7:1], 1'b0};
          video_tu_pkg::active_pixels_per_line_off: s_rdata_reg <= {16'h0000, active_pixels_per_line_reg};
          video_tu_pkg::bpp_off: s_rdata_reg <= {26'h000_0000, bpp_reg};
          video_tu_pkg::vbw_off: s_rdata_reg <= {16'h0000, vbw_reg};
          video_tu_pkg::lbw_off: s_rdata_reg <= {16'h0000, lbw_reg};
          video_tu_pkg::status_off: s_rdata_reg <= {29'h0000_0000,
            err_reg, done_reg, busy_reg};
          video_tu_pkg::res_lwc_off: s_rdata_reg <= lwc_reg;
          video_tu_pkg::res_tu_off: s_rdata_reg <= {5'h00, delay_reg,
            2'h0, frac_reg, 1'b0, whole_reg};
          default: begin
            s_rdata_reg <= 32'h0000_0000;
            s_rresp_reg <= video_tu_pkg::resp_slverr;
          end
        endcase
      end else if (s_axi_rready) begin
        s_rvalid_reg <= 1'b0;
      end
    end
  end

  // Word total and per-lane count from the live configuration
  always_comb begin
    pix_bits = active_pixels_per_line_reg * bpp_reg;
    words = {14'h0000, pix_bits[21:video_tu_pkg::word_shift]} +
            {31'h0000_0000, |pix_bits[video_tu_pkg::word_shift-1:0]};
    if (ctrl_reg[video_tu_pkg::ctrl_mst_bit] ||
        ctrl_reg[video_tu_pkg::ctrl_lane_lsb +: 2] ==
        video_tu_pkg::lanes_four) begin
      lwc_next = words + {30'h0000_0000, words[1:0]} - 32'h4;
    end else if (ctrl_reg[video_tu_pkg::ctrl_lane_lsb +: 2] ==
                 video_tu_pkg::lanes_two) begin
      lwc_next = words + {31'h0000_0000, words[0]} - 32'h2;
    end else begin
      lwc_next = words - 32'h1;
    end
    dividend = DIV_W'({vbw_reg, (ctrl_reg[video_tu_pkg::ctrl_tu64_bit] ?
      video_tu_pkg::tu_len_long : video_tu_pkg::tu_len_short)} >> 7) *
      DIV_W'(ctrl_reg[video_tu_pkg::ctrl_tu64_bit] ?
      video_tu_pkg::tu_len_long : video_tu_pkg::tu_len_short)
      << video_tu_pkg::frac_bits;
  end

  // Line start delay from the quotient once division ends
  always_comb begin
    whole_next = quo_reg[video_tu_pkg::frac_bits +: 7];
    diff = tu_reg - whole_next;
    diff_third = 16'((diff * video_tu_pkg::third_mul) >>
                     video_tu_pkg::third_shift);
    if (whole_next <= video_tu_pkg::small_whole_limit) begin
      delay_next = video_tu_pkg::small_whole_delay;
    end else if (ctrl_reg[video_tu_pkg::ctrl_fmt_lsb +: 2] ==
                 video_tu_pkg::fmt_422) begin
      delay_next = diff >> 1;
    end else if (ctrl_reg[video_tu_pkg::ctrl_fmt_lsb +: 2] ==
                 video_tu_pkg::fmt_y_only) begin
      delay_next = diff_third[6:0];
    end else begin
      delay_next = diff;
    end
  end

  assign trial = {rem_reg[15:0], quo_reg[DIV_W-1]};

  // Sequencer: divide, then program the five device registers in order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= video_tu_pkg::st_idle;
      idx_reg <= 3'h0;
      cnt_reg <= '0;
      quo_reg <= '0;
      rem_reg <= 17'h0_0000;
      lwc_reg <= 32'h0000_0000;
      ilace_reg <= 1'b0;
      tu_reg <= video_tu_pkg::tu_len_long;
      whole_reg <= 7'h00;
      frac_reg <= 10'h000;
      delay_reg <= video_tu_pkg::line_start_delay_rst;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      m_awvalid_reg <= 1'b0;
      m_wvalid_reg <= 1'b0;
      m_bready_reg <= 1'b0;
      m_awaddr_reg <= 32'h0000_0000;
      m_wdata_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        video_tu_pkg::st_idle: begin
          if (start_pulse) begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            lwc_reg <= lwc_next;
            ilace_reg <= ctrl_reg[video_tu_pkg::ctrl_ilace_bit];
            tu_reg <= ctrl_reg[video_tu_pkg::ctrl_tu64_bit] ?
              video_tu_pkg::tu_len_long : video_tu_pkg::tu_len_short;
            quo_reg <= dividend;
            rem_reg <= 17'h0_0000;
            cnt_reg <= '0;
            idx_reg <= 3'h0;
            state_reg <= video_tu_pkg::st_divide;
          end
        end
        video_tu_pkg::st_divide: begin
          // One quotient bit a cycle keeps the divider small
          if (trial >= {1'b0, lbw_reg}) begin
            rem_reg <= trial - {1'b0, lbw_reg};
            quo_reg <= {quo_reg[DIV_W-2:0], 1'b1};
          end else begin
            rem_reg <= trial;
            quo_reg <= {quo_reg[DIV_W-2:0], 1'b0};
          end
          if (cnt_reg == ($clog2(DIV_W+1))'(DIV_W - 1)) begin
            state_reg <= video_tu_pkg::st_write;
            m_awvalid_reg <= 1'b1;
            m_wvalid_reg <= 1'b1;
            m_awaddr_reg <= DEV_BASE + {20'h0_0000, dev_off(3'h0)};
            m_wdata_reg <= lwc_reg;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        video_tu_pkg::st_write: begin
          if (idx_reg == 3'h0) begin
            whole_reg <= whole_next;
            frac_reg <= quo_reg[video_tu_pkg::frac_bits-1:0];
            delay_reg <= delay_next;
          end
          if (!aw_left && !w_left) begin
            m_awvalid_reg <= 1'b0;
            m_wvalid_reg <= 1'b0;
            m_bready_reg <= 1'b1;
            state_reg <= video_tu_pkg::st_resp;
          end else begin
            m_awvalid_reg <= aw_left;
            m_wvalid_reg <= w_left;
          end
        end
        video_tu_pkg::st_resp: begin
          if (m_axi_bvalid) begin
            m_bready_reg <= 1'b0;
            err_reg <= err_reg || (m_axi_bresp != video_tu_pkg::resp_okay);
            if (idx_reg == video_tu_pkg::dev_reg_last) begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              state_reg <= video_tu_pkg::st_idle;
            end else begin
              idx_reg <= idx_reg + 3'h1;
              m_awvalid_reg <= 1'b1;
              m_wvalid_reg <= 1'b1;
              m_awaddr_reg <= DEV_BASE +
                {20'h0_0000, dev_off(idx_reg + 3'h1)};
              m_wdata_reg <= dev_data(idx_reg + 3'h1, lwc_reg, ilace_reg,
                whole_reg, frac_reg, delay_reg);
              state_reg <= video_tu_pkg::st_write;
            end
          end
        end
      endcase
    end
  end

  assign aw_left = m_awvalid_reg && !m_axi_awready;
  assign w_left = m_wvalid_reg && !m_axi_wready;

  assign s_axi_awready = s_wready_reg;
  assign s_axi_wready = s_wready_reg;
  assign s_axi_bvalid = s_bvalid_reg;
  assign s_axi_bresp = s_bresp_reg;
  assign s_axi_arready = s_arready_reg;
  assign s_axi_rvalid = s_rvalid_reg;
  assign s_axi_rdata = s_rdata_reg;
  assign s_axi_rresp = s_rresp_reg;
  assign m_axi_awaddr = m_awaddr_reg;
  assign m_axi_awvalid = m_awvalid_reg;
  assign m_axi_wdata = m_wdata_reg;
  assign m_axi_wstrb = 4'hf;
  assign m_axi_wvalid = m_wvalid_reg;
  assign m_axi_bready = m_bready_reg;
endmodule

/* core/video_tu_pkg.sv */
// Constants for the transfer-unit framing register host controller
package video_tu_pkg;
  // Device register map, written over the device's own register port
  localparam logic [11:0] lane_word_count_off = 12'h1bc;
  localparam logic [11:0] interlace_flag_off = 12'h1c0;
  localparam logic [11:0] tu_whole_bytes_off = 12'h1c4;
  localparam logic [11:0] tu_fraction_bytes_off = 12'h1c8;
  localparam logic [11:0] line_start_delay_off = 12'h1cc;
  localparam logic [6:0] line_start_delay_rst = 7'h20;
  localparam logic [2:0] dev_reg_last = 3'h4;
  // Own register map, reached over the AXI4-Lite slave
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] active_pixels_per_line_off = 8'h04;
  localparam logic [7:0] bpp_off = 8'h08;
  localparam logic [7:0] vbw_off = 8'h0c;
  localparam logic [7:0] lbw_off = 8'h10;
  localparam logic [7:0] status_off = 8'h14;
  localparam logic [7:0] res_lwc_off = 8'h18;
  localparam logic [7:0] res_tu_off = 8'h1c;
  // Control fields
  localparam int ctrl_start_bit = 0;
  localparam int ctrl_lane_lsb = 1;
  localparam int ctrl_mst_bit = 3;
  localparam int ctrl_fmt_lsb = 4;
  localparam int ctrl_ilace_bit = 6;
  localparam int ctrl_tu64_bit = 7;
  localparam logic [7:0] ctrl_rst = 8'h80;
  // Status fields
  localparam int stat_busy_bit = 0;
  localparam int stat_done_bit = 1;
  localparam int stat_err_bit = 2;
  // Result field positions in res_tu
  localparam int res_frac_lsb = 8;
  localparam int res_delay_lsb = 20;
  // Framing arithmetic
  localparam int word_shift = 4;
  localparam int frac_bits = 10;
  localparam logic [6:0] tu_len_short = 7'h20;
  localparam logic [6:0] tu_len_long = 7'h40;
  localparam logic [6:0] small_whole_limit = 7'h04;
  localparam logic [6:0] small_whole_delay = 7'h40;
  localparam logic [8:0] third_mul = 9'hab;
  localparam int third_shift = 9;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0] {
    lanes_one = 2'h0,
    lanes_two = 2'h1,
    lanes_four = 2'h2
  } lanes_t;
  typedef enum logic [1:0] {
    fmt_rgb_444 = 2'h0,
    fmt_422 = 2'h1,
    fmt_y_only = 2'h2
  } fmt_t;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_divide = 2'h1,
    st_write = 2'h3,
    st_resp = 2'h2
  } state_t;
endpackage

/* tb/video_tu_framing_host_properties.sv */
// Port-level checks for the framing host controller
`timescale 1ns/1ps
module video_tu_framing_checker #(
  parameter logic [31:0] DEV_BASE = 32'h0000_0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] m_axi_awaddr,
  input wire logic m_axi_awvalid,
  input wire logic m_axi_awready,
  input wire logic [31:0] m_axi_wdata,
  input wire logic [3:0] m_axi_wstrb,
  input wire logic m_axi_wvalid,
  input wire logic m_axi_wready,
  input wire logic m_axi_bvalid,
  input wire logic m_axi_bready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("write readies differ");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_awready && !s_axi_bvalid |=> s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready ##1 s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  m_aw_hold_a: assert property (m_axi_awvalid && !m_axi_awready |=>
    m_axi_awvalid && $stable(m_axi_awaddr)) else $error("awaddr dropped");
  m_w_hold_a: assert property (m_axi_wvalid && !m_axi_wready |=>
    m_axi_wvalid && $stable(m_axi_wdata)) else $error("wdata dropped");
  m_pair_a: assert property ($rose(m_axi_awvalid) |-> $rose(m_axi_wvalid))
    else $error("device valids apart");
  m_strb_a: assert property (m_axi_wstrb == 4'hf)
    else $error("partial device write");
  m_single_a: assert property (m_axi_bready |->
    !m_axi_awvalid && !m_axi_wvalid) else $error("second write early");
  m_bdone_a: assert property (m_axi_bready && m_axi_bvalid |=>
    !m_axi_bready) else $error("bready held after response");
  dev_order_a: assert property (
    $rose(m_axi_awvalid) |-> m_axi_awaddr == DEV_BASE + 32'h1bc ||
    (m_axi_awaddr == $past(m_axi_awaddr) + 32'h4 &&
    m_axi_awaddr <= DEV_BASE + 32'h1cc)) else $error("device order");
endmodule

/* tb/video_tu_dev_model.sv */
// Behavioural transmitter register port holding the framing words
`timescale 1ns/1ps
module video_tu_dev_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic slow,
  input wire logic err,
  output logic [31:0] lwc,
  output logic [31:0] il,
  output logic [31:0] whole,
  output logic [31:0] frac,
  output logic [31:0] dly
);
  logic got_a, got_w, go, fire;
  logic [31:0] addr, data;
  logic [2:0] cnt;
  assign go = slow ? (cnt == 3'h3) : 1'b1;
  assign fire = got_a && got_w && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready, wready, bvalid, got_a, got_w} <= 5'h0;
      bresp <= 2'h1;
      cnt <= 3'h0;
      addr <= 32'h0;
      data <= 32'h0;
    end else begin
      awready <= awvalid && !awready && !got_a && go;
      wready <= wvalid && !wready && !got_w && go;
      if ((awvalid || wvalid) && cnt != 3'h3) cnt <= cnt + 3'h1;
      if (awready) begin
        got_a <= 1'b1;
        addr <= awaddr;
      end
      if (wready) begin
        got_w <= 1'b1;
        data <= wdata;
      end
      if (fire) begin
        {bvalid, got_a, got_w} <= 3'h4;
        bresp <= err ? 2'h2 : 2'h0;
      end
      // Idle response code is junk, not the last answer
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        bresp <= 2'h1;
        cnt <= 3'h0;
      end
    end
  end
  // Framing logic reads these words at each line and transfer unit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {lwc, il, whole, frac} <= 128'h0;
      dly <= {25'h0, video_tu_pkg::line_start_delay_rst};
    end else if (fire) begin
      case (addr[11:0])
        video_tu_pkg::lane_word_count_off: lwc <= data;
        video_tu_pkg::interlace_flag_off: il <= data;
        video_tu_pkg::tu_whole_bytes_off: whole <= data;
        video_tu_pkg::tu_fraction_bytes_off: frac <= data;
        video_tu_pkg::line_start_delay_off: dly <= data;
        default: ;
      endcase
    end
  end
endmodule

/* tb/video_tu_framing_regs_tb_top.sv */
// Self-checking bench for the framing host controller
`timescale 1ns/1ps
module video_tu_framing_regs_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, slow = 1'b0, err = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, m_bresp;
  logic [31:0] rdata, m_awaddr, m_wdata, lwc, il, whole, frac, dly;
  logic [3:0] m_wstrb;
  logic m_awvalid, m_awready, m_wvalid, m_wready, m_bvalid, m_bready;
  int n_errors = 0;
  int cmp_count = 0;
  always #12.5 aclk = ~aclk;
  video_tu_framing_host i_video_tu_framing_host (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .m_axi_awaddr(m_awaddr),
    .m_axi_awvalid(m_awvalid), .m_axi_awready(m_awready),
    .m_axi_wdata(m_wdata), .m_axi_wstrb(m_wstrb), .m_axi_wvalid(m_wvalid),
    .m_axi_wready(m_wready), .m_axi_bresp(m_bresp),
    .m_axi_bvalid(m_bvalid), .m_axi_bready(m_bready));
  video_tu_dev_model i_video_tu_dev_model (.aclk(aclk), .aresetn(aresetn),
    .awaddr(m_awaddr), .awvalid(m_awvalid), .awready(m_awready),
    .wdata(m_wdata), .wvalid(m_wvalid), .wready(m_wready),
    .bresp(m_bresp), .bvalid(m_bvalid), .bready(m_bready), .slow(slow),
    .err(err), .lwc(lwc), .il(il), .whole(whole), .frac(frac), .dly(dly));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Expected words are worked out here, never read back from the host
  task automatic run_cfg(input int ln, multi_stream_mode, fmt, ilc, t64, active_pixels_per_line, bpp,
                         input int vbw, lbw);
    int w, n, tu, wh, fr, dl, lw;
    longint q;
    logic [31:0] d;
    logic [31:0] c;
    logic [1:0] r;
    w = (active_pixels_per_line * bpp + 15) / 16;
    n = multi_stream_mode ? 4 : ln;
    lw = (n == 1) ? w - 1 : w + (w % n) - n;
    tu = t64 ? 64 : 32;
    q = longint'(vbw) * tu * 1024 / lbw;
    wh = int'(q >> 10) & 127;
    fr = int'(q) & 1023;
    dl = (wh <= 4) ? 64 : (tu - wh) / (fmt + 1);
    wr(video_tu_pkg::active_pixels_per_line_off, 32'(active_pixels_per_line), r);
    wr(video_tu_pkg::bpp_off, 32'(bpp), r);
    wr(video_tu_pkg::vbw_off, 32'(vbw), r);
    wr(video_tu_pkg::lbw_off, 32'(lbw), r);
    c = {24'h0, t64[0], ilc[0], fmt[1:0], multi_stream_mode[0],
         (ln == 4) ? 2'h2 : 2'(ln >> 1), 1'b0};
    // Start captures the control word already held, so settle it first
    wr(video_tu_pkg::ctrl_off, c, r);
    wr(video_tu_pkg::ctrl_off, c | 32'h1, r);
    do rd(video_tu_pkg::status_off, d, r); while (d[1] !== 1'b1);
    chk(d, {29'h0, err, 2'h2});
    chk(lwc, 32'(lw));
    chk(il & 32'h1, 32'(ilc));
    chk(whole, 32'(wh));
    chk(frac, 32'(fr));
    chk(dly, 32'(dl));
    rd(video_tu_pkg::res_lwc_off, d, r);
    chk(d, 32'(lw));
    rd(video_tu_pkg::res_tu_off, d, r);
    chk(d, 32'(wh | (fr << 8) | (dl << 20)));
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(video_tu_pkg::ctrl_off, d, r);
    chk(d, 32'h80);
    rd(video_tu_pkg::status_off, d, r);
    chk(d, 32'h0);
    chk(dly, 32'h20);
    $display("reset test done");
  endtask
  task automatic t_refuse;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h20, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'h2);
    // Only the low byte lane may land
    wstrb <= 4'h1;
    wr(video_tu_pkg::active_pixels_per_line_off, 32'h0000_5678, r);
    wstrb <= 4'hf;
    rd(video_tu_pkg::active_pixels_per_line_off, d, r);
    chk(d, 32'h78);
    wr(8'h24, 32'h1, r);
    chk(32'(r), 32'h2);
    wr(video_tu_pkg::status_off, 32'hff, r);
    rd(video_tu_pkg::status_off, d, r);
    chk(d, 32'h0);
    $display("refusal test done");
  endtask
  task automatic t_one_lane;
    run_cfg(1, 0, 0, 1, 1, 1920, 24, 100, 270);
    $display("one lane test done");
  endtask
  task automatic t_two_lane_slow;
    slow <= 1'b1;
    run_cfg(2, 0, 1, 0, 0, 17, 16, 50, 100);
    slow <= 1'b0;
    $display("two lane test done");
  endtask
  task automatic t_multi_stream;
    run_cfg(1, 1, 2, 0, 1, 11, 18, 81, 100);
    $display("multi-stream test done");
  endtask
  task automatic t_small_err;
    err <= 1'b1;
    run_cfg(4, 0, 0, 0, 1, 8, 8, 4, 64);
    err <= 1'b0;
    $display("small unit test done");
  endtask
  task automatic complete_run;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_refuse();
    t_one_lane();
    t_two_lane_slow();
    t_multi_stream();
    t_small_err();
    complete_run();
  end
  // The whole sequence needs about four hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
bind video_tu_framing_host video_tu_framing_checker #(.DEV_BASE(DEV_BASE))
  i_video_tu_framing_checker (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .m_axi_awaddr(m_axi_awaddr), .m_axi_awvalid(m_axi_awvalid),
  .m_axi_awready(m_axi_awready), .m_axi_wdata(m_axi_wdata),
  .m_axi_wstrb(m_axi_wstrb), .m_axi_wvalid(m_axi_wvalid),
  .m_axi_wready(m_axi_wready), .m_axi_bvalid(m_axi_bvalid),
  .m_axi_bready(m_axi_bready));
